// *** core/lcdcd_core.sv ***
// LCD configuration command decoder with its AHB-Lite register slave.
// Assumes one AHB-Lite master, single word transfers, hready taken from this slave.
`timescale 1ns/1ps
`default_nettype none

module lcdcd_core
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [1:0] pixel_code,
	input wire logic [1:0] frame_sel,
	output logic [3:0] frame_level,
	output logic booster_on,
	output logic regulator_on,
	output logic buffer_on
);

	lcdcd_pkg::lcdcd_regs_t r;
	lcdcd_pkg::lcdcd_regs_t next_r;
	logic addr_ok;
	logic cmd_stb;
	logic [7:0] cmd_byte;
	logic [7:0] duty;
	logic [31:0] rd_word;
	logic [7:0] rd_off;

	// Address phase qualifier; command strobe in the write data phase
	assign addr_ok = hsel && htrans[1] && hready;
	assign cmd_stb = r.wr_pend && (r.wr_off == lcdcd_pkg::lcdcd_off_cmd);
	assign cmd_byte = hwdata[7:0];
	assign rd_off = {haddr[7:2], 2'b00};
	assign duty = r.mux + {7'h00, r.symbol_row};

	// Zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = r.rdata;
	assign frame_level = r.frame_level;
	assign booster_on = r.booster;
	assign regulator_on = r.regulator;
	assign buffer_on = r.buffer;

	// Read multiplexer; unmapped words read zero
	always_comb
	begin
		rd_word = 32'h0000_0000;
		// Command status: waiting flag and last opcode
		if (rd_off == lcdcd_pkg::lcdcd_off_cmd)
		begin
			rd_word = {16'h0000, r.opcode, 7'h00, r.phase == lcdcd_pkg::lcdcd_param};
		end
		// Pointers: column, page, start line, row offset
		else if (rd_off == lcdcd_pkg::lcdcd_off_addr)
		begin
			rd_word[6:0] = r.col;
			rd_word[lcdcd_pkg::lcdcd_pos_page +: 5] = r.page;
			rd_word[lcdcd_pkg::lcdcd_pos_start +: 7] = r.start_line;
			rd_word[lcdcd_pkg::lcdcd_pos_offset +: 7] = r.row_offset;
		end
		// Power, bias, converter, symbol row and gray mode
		else if (rd_off == lcdcd_pkg::lcdcd_off_power)
		begin
			rd_word[2:0] = r.gain;
			rd_word[lcdcd_pkg::lcdcd_pos_booster +: 3] = {r.buffer, r.regulator, r.booster};
			rd_word[lcdcd_pkg::lcdcd_pos_bias +: 3] = r.bias;
			rd_word[lcdcd_pkg::lcdcd_pos_dcdc +: 2] = r.dcdc;
			rd_word[lcdcd_pkg::lcdcd_pos_symbol] = r.symbol_row;
			rd_word[lcdcd_pkg::lcdcd_pos_frc +: 3] = {r.pwm, r.frame_count_select};
		end
		// Multiplex, effective duty, inversion, contrast
		else if (rd_off == lcdcd_pkg::lcdcd_off_disp)
		begin
			rd_word[7:0] = r.mux;
			rd_word[lcdcd_pkg::lcdcd_pos_duty +: 8] = duty;
			rd_word[lcdcd_pkg::lcdcd_pos_inv +: 5] = r.inversion;
			rd_word[lcdcd_pkg::lcdcd_pos_contrast +: 6] = r.contrast;
		end
		// White and light gray palettes
		else if (rd_off == lcdcd_pkg::lcdcd_off_pal_lo)
		begin
			rd_word = {r.palette[1], r.palette[0]};
		end
		// Dark gray and dark palettes
		else if (rd_off == lcdcd_pkg::lcdcd_off_pal_hi)
		begin
			rd_word = {r.palette[3], r.palette[2]};
		end
	end

	// Next state: bus phases and command decoding
	always_comb
	begin
		next_r = r;
		next_r.wr_pend = addr_ok && hwrite;
		next_r.wr_off = {haddr[7:2], 2'b00};
		if (addr_ok && !hwrite)
		begin
			next_r.rdata = rd_word;
		end
		next_r.frame_level = r.palette[pixel_code][frame_sel];
		if (cmd_stb)
		begin
			case (r.phase)
				lcdcd_pkg::lcdcd_param:
				begin
					// Parameter byte of the held opcode
					next_r.phase = lcdcd_pkg::lcdcd_idle;
					if (r.opcode[7:2] == lcdcd_pkg::lcdcd_op_start)
					begin
						next_r.start_line = cmd_byte[6:0];
					end
					else if (r.opcode[7:2] == lcdcd_pkg::lcdcd_op_offset)
					begin
						next_r.row_offset = cmd_byte[6:0];
					end
					else if (r.opcode[7:2] == lcdcd_pkg::lcdcd_op_mux)
					begin
						if (cmd_byte >= lcdcd_pkg::lcdcd_mux_min && cmd_byte <= lcdcd_pkg::lcdcd_mux_max)
						begin
							next_r.mux = cmd_byte;
						end
					end
					else if (r.opcode[7:2] == lcdcd_pkg::lcdcd_op_inv)
					begin
						next_r.inversion = cmd_byte[4:0];
					end
					else if (r.opcode == lcdcd_pkg::lcdcd_op_contrast)
					begin
						next_r.contrast = cmd_byte[5:0];
					end
					else if (r.opcode[7:3] == lcdcd_pkg::lcdcd_op_palette)
					begin
						// Even opcode: frames 2 and 1; odd opcode: frames 4 and 3
						next_r.palette[r.opcode[2:1]][{r.opcode[0], 1'b1}] = cmd_byte[7:4];
						next_r.palette[r.opcode[2:1]][{r.opcode[0], 1'b0}] = cmd_byte[3:0];
					end
				end
				default:
				begin
					next_r.opcode = cmd_byte;
					if (cmd_byte[7:4] == 4'h0)
					begin
						next_r.col[3:0] = cmd_byte[3:0];
					end
					else if (cmd_byte[7:3] == 5'h02)
					begin
						next_r.col[6:4] = cmd_byte[2:0];
					end
					else if (cmd_byte[7:3] == 5'h04)
					begin
						next_r.gain = cmd_byte[2:0];
					end
					else if (cmd_byte[7:3] == 5'h05)
					begin
						next_r.booster = cmd_byte[2];
						next_r.regulator = cmd_byte[1];
						next_r.buffer = cmd_byte[0];
					end
					else if (cmd_byte[7:4] == 4'h4 || cmd_byte == lcdcd_pkg::lcdcd_op_contrast
						|| cmd_byte[7:3] == lcdcd_pkg::lcdcd_op_palette)
					begin
						next_r.phase = lcdcd_pkg::lcdcd_param;
					end
					else if (cmd_byte[7:3] == 5'h0a)
					begin
						next_r.bias = cmd_byte[2:0];
					end
					else if (cmd_byte[7:2] == 6'h19)
					begin
						next_r.dcdc = cmd_byte[1:0];
					end
					else if (cmd_byte[7:3] == 5'h12)
					begin
						next_r.frame_count_select = cmd_byte[2];
						next_r.pwm = cmd_byte[1:0];
					end
					else if (cmd_byte[7:1] == lcdcd_pkg::lcdcd_op_symbol)
					begin
						next_r.symbol_row = cmd_byte[0];
						if (cmd_byte[0])
						begin
							next_r.page = lcdcd_pkg::lcdcd_symbol_page;
						end
					end
				end
			endcase
		end
	end

	// State register with reset defaults
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			r <= '0;
			r.mux <= lcdcd_pkg::lcdcd_rst_mux;
			r.contrast <= lcdcd_pkg::lcdcd_rst_contrast;
			r.bias <= lcdcd_pkg::lcdcd_rst_bias;
			r.palette <= {lcdcd_pkg::lcdcd_rst_pal_dark, lcdcd_pkg::lcdcd_rst_pal_dark,
				lcdcd_pkg::lcdcd_rst_pal_light, lcdcd_pkg::lcdcd_rst_pal_light};
		end
		else
		begin
			r <= next_r;
		end
	end

	// Assertions share the bus clock and stay quiet while reset is held
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence idle_cmd_s;
		cmd_stb && r.phase == lcdcd_pkg::lcdcd_idle;
	endsequence

	sequence param_cmd_s;
		cmd_stb && r.phase == lcdcd_pkg::lcdcd_param;
	endsequence

	sequence two_byte_s;
		cmd_byte[7:4] == 4'h4 || cmd_byte == lcdcd_pkg::lcdcd_op_contrast
			|| cmd_byte[7:3] == lcdcd_pkg::lcdcd_op_palette;
	endsequence

	// Each opcode or accepted parameter lands in its own setting; an out-of-range multiplex is refused
	col_low_a: assert property (idle_cmd_s ##0 cmd_byte[7:4] == 4'h0
		|=> r.col[3:0] == $past(cmd_byte[3:0]) && $stable(r.col[6:4]))
		else $error("column low nibble not loaded");
	col_high_a: assert property (idle_cmd_s ##0 cmd_byte[7:3] == 5'h02
		|=> r.col[6:4] == $past(cmd_byte[2:0]) && $stable(r.col[3:0]))
		else $error("column upper bits not loaded");
	gain_a: assert property (idle_cmd_s ##0 cmd_byte[7:3] == 5'h04
		|=> r.gain == $past(cmd_byte[2:0]))
		else $error("regulator gain not stored");
	power_a: assert property (idle_cmd_s ##0 cmd_byte[7:3] == 5'h05
		|=> {booster_on, regulator_on, buffer_on} == $past(cmd_byte[2:0]))
		else $error("power enables wrong");
	start_line_a: assert property (param_cmd_s
		##0 r.opcode[7:2] == lcdcd_pkg::lcdcd_op_start
		|=> r.start_line == $past(cmd_byte[6:0]))
		else $error("start line not taken from parameter");
	offset_a: assert property (param_cmd_s
		##0 r.opcode[7:2] == lcdcd_pkg::lcdcd_op_offset
		|=> r.row_offset == $past(cmd_byte[6:0]))
		else $error("row offset not taken");
	mux_range_a: assert property (r.mux >= lcdcd_pkg::lcdcd_mux_min
		&& r.mux <= lcdcd_pkg::lcdcd_mux_max)
		else $error("multiplex outside valid range");
	mux_hold_a: assert property (param_cmd_s
		##0 r.opcode[7:2] == lcdcd_pkg::lcdcd_op_mux
		##0 (cmd_byte < lcdcd_pkg::lcdcd_mux_min || cmd_byte > lcdcd_pkg::lcdcd_mux_max)
		|=> $stable(r.mux))
		else $error("invalid multiplex accepted");
	inversion_a: assert property (param_cmd_s
		##0 r.opcode[7:2] == lcdcd_pkg::lcdcd_op_inv
		|=> r.inversion == $past(cmd_byte[4:0]))
		else $error("inversion code not taken");
	bias_dcdc_a: assert property (idle_cmd_s ##0 cmd_byte[7:3] == 5'h0a
		|=> r.bias == $past(cmd_byte[2:0]) && $stable(r.dcdc))
		else $error("bias code not stored");
	contrast_a: assert property (param_cmd_s
		##0 r.opcode == lcdcd_pkg::lcdcd_op_contrast
		|=> r.contrast == $past(cmd_byte[5:0]))
		else $error("contrast not taken");
	palette_a: assert property (param_cmd_s ##0 r.opcode == 8'h8d
		|=> r.palette[2][3] == $past(cmd_byte[7:4])
		&& r.palette[2][2] == $past(cmd_byte[3:0]))
		else $error("dark gray frames 4 and 3 not loaded");
	param_only_a: assert property (param_cmd_s
		|=> r.phase == lcdcd_pkg::lcdcd_idle && $stable(r.col) && $stable(r.opcode))
		else $error("parameter byte decoded as opcode");
	frame_sel_a: assert property (hresetn
		|=> frame_level == $past(r.palette[pixel_code][frame_sel]))
		else $error("frame level from wrong palette");
	symbol_a: assert property (idle_cmd_s ##0 cmd_byte == 8'ha3
		|=> r.page == lcdcd_pkg::lcdcd_symbol_page && duty == r.mux + 8'h01)
		else $error("symbol row enable effect missing");
	frc_a: assert property (idle_cmd_s ##0 cmd_byte[7:3] == 5'h12
		|=> {r.pwm, r.frame_count_select} == {$past(cmd_byte[1:0]), $past(cmd_byte[2])})
		else $error("frame count or level field wrong");

	// Two-byte entry, opcode latch, accepted parameters, converter factor and symbol row off
	param_enter_a: assert property (idle_cmd_s ##0 two_byte_s
		|=> r.phase == lcdcd_pkg::lcdcd_param)
		else $error("two-byte opcode did not wait for its parameter");
	opcode_latch_a: assert property (idle_cmd_s
		|=> r.opcode == $past(cmd_byte))
		else $error("opcode byte not latched");
	mux_take_a: assert property (param_cmd_s
		##0 r.opcode[7:2] == lcdcd_pkg::lcdcd_op_mux
		##0 (cmd_byte >= lcdcd_pkg::lcdcd_mux_min && cmd_byte <= lcdcd_pkg::lcdcd_mux_max)
		|=> r.mux == $past(cmd_byte))
		else $error("valid multiplex not taken");
	dcdc_a: assert property (idle_cmd_s ##0 cmd_byte[7:2] == 6'h19
		|=> r.dcdc == $past(cmd_byte[1:0]) && $stable(r.bias))
		else $error("converter factor not stored");
	symbol_off_a: assert property (idle_cmd_s ##0 cmd_byte == 8'ha2
		|=> !r.symbol_row && duty == r.mux && $stable(r.page))
		else $error("symbol row disable effect wrong");
	palette_even_a: assert property (param_cmd_s ##0 r.opcode == 8'h88
		|=> r.palette[0][1] == $past(cmd_byte[7:4])
		&& r.palette[0][0] == $past(cmd_byte[3:0]))
		else $error("white frames 2 and 1 not loaded");

	// Settings that other bytes must leave alone
	power_hold_a: assert property (cmd_stb
		&& (r.phase == lcdcd_pkg::lcdcd_param || cmd_byte[7:3] != 5'h05)
		|=> $stable({booster_on, regulator_on, buffer_on}))
		else $error("power enables changed by another byte");
	idle_keep_a: assert property (idle_cmd_s
		|=> $stable(r.start_line) && $stable(r.row_offset) && $stable(r.mux)
		&& $stable(r.inversion) && $stable(r.contrast))
		else $error("one-byte command changed a parameter setting");

endmodule

`default_nettype wire

// *** pkg/lcdcd_pkg.sv ***
// Constants, types and register layout of the LCD configuration command decoder.
// Assumes an AHB-Lite slave wrapper in the core that feeds command bytes from a bus register.
// What this block does
// - Opcode 0000xxxx loads low nibble of column pointer; pointer resets to zero.
// - Opcode 00010xxx loads upper three column pointer bits; pointer resets to zero.
// - Opcode 00100xxx stores regulator gain code; code 000 after reset.
// - Opcode 00101xxx sets booster, regulator and buffer enables; all off after reset.
// - Opcode 010000xx then byte sets display start line 0-127; resets to zero.
// - Opcode 010001xx then byte sets display row offset 0-127; resets to zero.
// - Opcode 010010xx then byte sets multiplex 16-128; symbol row adds one line.
// - Opcode 010011xx then byte sets five-bit inversion code; zero disables, resets zero.
// - Opcode 01010xxx stores bias code; 111 (1/12) after reset.
// - Opcode 011001xx stores converter factor 3X-6X; 3X after reset.
// - Opcode 10000001 then byte sets six-bit contrast level.
// - Opcodes 10001000-10001111 then byte load two frame levels of one palette.
// - White and light gray palettes reset to 0000; dark gray and dark to 1111.
// - Two pixel bits, first-byte bit high, select which palette gives frame level.
// - Opcode 10010xxx sets frame-count bit and two-bit level field; zero after reset.
// - Symbol row enable extends multiplex by one and forces page pointer to 16.
package lcdcd_pkg;

	// Word offsets of the bus registers
	localparam logic [7:0] lcdcd_off_cmd = 8'h00;
	localparam logic [7:0] lcdcd_off_addr = 8'h04;
	localparam logic [7:0] lcdcd_off_power = 8'h08;
	localparam logic [7:0] lcdcd_off_disp = 8'h0c;
	localparam logic [7:0] lcdcd_off_pal_lo = 8'h10;
	localparam logic [7:0] lcdcd_off_pal_hi = 8'h14;

	// Reset values
	localparam logic [7:0] lcdcd_rst_mux = 8'h80;
	localparam logic [5:0] lcdcd_rst_contrast = 6'h20;
	localparam logic [2:0] lcdcd_rst_bias = 3'h7;
	localparam logic [15:0] lcdcd_rst_pal_light = 16'h0000;
	localparam logic [15:0] lcdcd_rst_pal_dark = 16'hffff;

	// Multiplex limits and forced page for the symbol row
	localparam logic [7:0] lcdcd_mux_min = 8'h10;
	localparam logic [7:0] lcdcd_mux_max = 8'h80;
	localparam logic [4:0] lcdcd_symbol_page = 5'h10;

	// Opcodes that take a parameter byte, and the one-byte symbol row opcode
	localparam logic [5:0] lcdcd_op_start = 6'h10;
	localparam logic [5:0] lcdcd_op_offset = 6'h11;
	localparam logic [5:0] lcdcd_op_mux = 6'h12;
	localparam logic [5:0] lcdcd_op_inv = 6'h13;
	localparam logic [7:0] lcdcd_op_contrast = 8'h81;
	localparam logic [4:0] lcdcd_op_palette = 5'h11;
	localparam logic [6:0] lcdcd_op_symbol = 7'h51;

	// Field positions inside the read registers
	localparam int lcdcd_pos_page = 8;
	localparam int lcdcd_pos_start = 16;
	localparam int lcdcd_pos_offset = 24;
	localparam int lcdcd_pos_booster = 4;
	localparam int lcdcd_pos_bias = 8;
	localparam int lcdcd_pos_dcdc = 12;
	localparam int lcdcd_pos_symbol = 16;
	localparam int lcdcd_pos_frc = 20;
	localparam int lcdcd_pos_duty = 8;
	localparam int lcdcd_pos_inv = 16;
	localparam int lcdcd_pos_contrast = 24;

	typedef enum logic {lcdcd_idle, lcdcd_param} lcdcd_phase_t;

	typedef struct packed {
		logic wr_pend;
		logic [7:0] wr_off;
		logic [31:0] rdata;
		lcdcd_phase_t phase;
		logic [7:0] opcode;
		logic [6:0] col;
		logic [4:0] page;
		logic [2:0] gain;
		logic booster;
		logic regulator;
		logic buffer;
		logic [6:0] start_line;
		logic [6:0] row_offset;
		logic [7:0] mux;
		logic [4:0] inversion;
		logic [2:0] bias;
		logic [1:0] dcdc;
		logic [5:0] contrast;
		logic [3:0][3:0][3:0] palette;
		logic frame_count_select;
		logic [1:0] pwm;
		logic symbol_row;
		logic [3:0] frame_level;
	} lcdcd_regs_t;

endpackage

// *** tb/lcdcd_core_tb.sv ***
// Self-checking bench for the command decoder.
// Assumes the host model drives the bus and hready is the slave's hreadyout.
`timescale 1ns/1ps
`default_nettype none

module lcdcd_core_tb;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel, hwrite, hready, hresp, booster_on, regulator_on, buffer_on;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [1:0] pixel_code = 2'h0;
	logic [1:0] frame_sel = 2'h0;
	logic [3:0] frame_level;
	logic [15:0] pal [4];
	int err_count = 0;
	int samples_checked = 0;

	// 40 MHz clock
	always #12.5 hclk = ~hclk;

	lcdcd_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .pixel_code(pixel_code),
		.frame_sel(frame_sel), .frame_level(frame_level), .booster_on(booster_on),
		.regulator_on(regulator_on), .buffer_on(buffer_on));

	lcdcd_host host (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

	// Verdict and end of run
	task automatic results();
		err_count += host.tmo;
		$display("mismatches %0d, comparisons %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// One transfer; a hung bus ends the run
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		host.xfer(w, a, wd, rd);
		if (host.tmo != 0)
		begin
			$display("unexpected at %0t: bus transfer timed out", $time);
			results();
		end
	endtask

	task automatic cmd(input logic [7:0] b);
		logic [31:0] d;
		bus(1'b1, lcdcd_pkg::lcdcd_off_cmd, {24'h0, b}, d);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		bus(1'b0, a, 32'h0, d);
		chk(d, exp);
	endtask

	// Every palette level through the pixel lookup port
	task automatic levels();
		for (int p = 0; p < 4; p++)
			for (int f = 0; f < 4; f++)
			begin
				pixel_code <= 2'(p);
				frame_sel <= 2'(f);
				repeat (2) @(posedge hclk);
				chk({28'h0, frame_level}, {28'h0, pal[p][4*f+:4]});
			end
	endtask

	// Power-on state, unmapped read, response code
	task automatic t_defaults();
		pal = '{16'h0000, 16'h0000, 16'hffff, 16'hffff};
		rchk(lcdcd_pkg::lcdcd_off_addr, 32'h0);
		rchk(lcdcd_pkg::lcdcd_off_power, 32'h0000_0700);
		rchk(lcdcd_pkg::lcdcd_off_disp, 32'h2000_8080);
		rchk(lcdcd_pkg::lcdcd_off_pal_lo, 32'h0);
		rchk(lcdcd_pkg::lcdcd_off_pal_hi, 32'hffff_ffff);
		rchk(8'h20, 32'h0);
		chk({29'h0, booster_on, regulator_on, buffer_on}, 32'h0);
		chk({31'h0, hresp}, 32'h0);
		levels();
	endtask

	// One-byte commands
	task automatic t_single();
		cmd(8'h0a);
		cmd(8'h15);
		cmd(8'h25);
		cmd(8'h2d);
		cmd(8'h52);
		cmd(8'h66);
		cmd(8'h97);
		rchk(lcdcd_pkg::lcdcd_off_addr, 32'h0000_005a);
		rchk(lcdcd_pkg::lcdcd_off_power, 32'h0070_2255);
		chk({29'h0, booster_on, regulator_on, buffer_on}, 32'h5);
		cmd(8'h2a);
		repeat (2) @(posedge hclk);
		chk({29'h0, booster_on, regulator_on, buffer_on}, 32'h2);
	endtask

	// Two-byte commands, opcode-like parameters, refused multiplex values
	task automatic t_two_byte();
		cmd(8'h81);
		rchk(lcdcd_pkg::lcdcd_off_cmd, 32'h0000_8101);
		cmd(8'h3f);
		cmd(8'h40);
		cmd(8'h81);
		cmd(8'h44);
		cmd(8'h7f);
		cmd(8'h48);
		cmd(8'h10);
		cmd(8'h48);
		cmd(8'h81);
		cmd(8'h48);
		cmd(8'h0f);
		cmd(8'h4c);
		cmd(8'h1f);
		rchk(lcdcd_pkg::lcdcd_off_addr, 32'h7f01_005a);
		rchk(lcdcd_pkg::lcdcd_off_disp, 32'h3f1f_1010);
		cmd(8'ha3);
		rchk(lcdcd_pkg::lcdcd_off_addr, 32'h7f01_105a);
		cmd(8'h48);
		cmd(8'h80);
		rchk(lcdcd_pkg::lcdcd_off_disp, 32'h3f1f_8180);
		cmd(8'ha2);
		rchk(lcdcd_pkg::lcdcd_off_disp, 32'h3f1f_8080);
	endtask

	// All eight palette opcodes, then the lookup port
	task automatic t_palette();
		logic [7:0] p;
		for (int i = 0; i < 8; i++)
		begin
			p = 8'(8'h17 * (i + 1));
			cmd(8'(8'h88 + i));
			cmd(p);
			pal[i/2][8*(i%2)+:8] = p;
		end
		rchk(lcdcd_pkg::lcdcd_off_pal_lo, {pal[1], pal[0]});
		rchk(lcdcd_pkg::lcdcd_off_pal_hi, {pal[3], pal[2]});
		levels();
	endtask

	// Main sequence, with a second reset in mid-run
	initial
	begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_defaults();
		t_single();
		t_two_byte();
		t_palette();
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_defaults();
		results();
	end
endmodule
`default_nettype wire

// *** tb/lcdcd_host.sv ***
// Host model: AHB-Lite master making single word transfers.
// Assumes one slave whose hreadyout comes back as hready.
`timescale 1ns/1ps
`default_nettype none

module lcdcd_host
(
	input wire logic hclk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	int tmo = 0;

	// Quiet bus at time zero
	initial
	begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end

	// Wait for hready at a rising edge, never forever
	task automatic wait_rdy();
		int n;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (hready !== 1'b1 && n < 50);
		if (n >= 50)
			tmo++;
	endtask

	// Address phase, then data phase; read data taken at the closing edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= w ? wd : ~hwdata;
		wait_rdy();
		rd = hrdata;
	endtask
endmodule
`default_nettype wire
